/* File: src/ctos_defs.svh */
`ifndef CTOS_DEFS_SVH
`define CTOS_DEFS_SVH

// ----------------------------------------------------------------
// Register byte offsets within the host memory window
// ----------------------------------------------------------------
`define CTOS_OFF_CTRL        16'h7070
`define CTOS_OFF_CMD         16'h7074
`define CTOS_OFF_IRQ_CLEAR   16'h7060
`define CTOS_OFF_IRQ_CAUSE   16'h7078
`define CTOS_OFF_READBACK    16'h707c
`define CTOS_OFF_CONST_A1    16'h7080
`define CTOS_OFF_CONST_A2    16'h7084
`define CTOS_OFF_CONST_B1    16'h7088
`define CTOS_OFF_CONST_B2    16'h708c

// ----------------------------------------------------------------
// Control register fields
// ----------------------------------------------------------------
`define CTOS_CTRL_WIDTH      16
`define CTOS_MODE_LSB        0
`define CTOS_MODE_MSB        2
`define CTOS_MODE_ONESHOT    3'h7
`define CTOS_POL_BIT         3
`define CTOS_GATE_LSB        4
`define CTOS_GATE_MSB        5
`define CTOS_TRIG_LSB        8
`define CTOS_TRIG_MSB        9
`define CTOS_RATE_LSB        10
`define CTOS_RATE_MSB        12
`define CTOS_CTRL_MASK       16'h1f3f
`define CTOS_CTRL_RESET      16'h0000
`define CTOS_SEL_ACT_LOW     2'h1
`define CTOS_SEL_ACT_HIGH    2'h2

// ----------------------------------------------------------------
// Command register bits (toggle is stored, the rest self-clear)
// ----------------------------------------------------------------
`define CTOS_CMD_TOGGLE      0
`define CTOS_CMD_TRIGGER     1
`define CTOS_CMD_RB_LOAD     2
`define CTOS_CMD_SOFT_RESET  3

// ----------------------------------------------------------------
// Interrupt information bits
// ----------------------------------------------------------------
`define CTOS_IRQ_WIDTH       6
`define CTOS_IRQ_TRANSITION  3

// ----------------------------------------------------------------
// Clock-enable rates in Hz and the system clock rate
// ----------------------------------------------------------------
`define CTOS_CLK_HZ          32'd10000000
`define CTOS_RATE_0_HZ       32'd1953125
`define CTOS_RATE_1_HZ       32'd3906250
`define CTOS_RATE_2_HZ       32'd7812500
`define CTOS_RATE_3_HZ       32'd15625000
`define CTOS_RATE_4_HZ       32'd62500000

`endif

/* File: src/ctos_oneshot_regs.sv */
`timescale 1ns/10ps
`include "ctos_defs.svh"

module ctos_oneshot_regs
(
    // Clock and reset
    input  wire logic               ref_clk,
    input  wire logic               reset_n,
    // Register access through the host memory window
    input  wire logic               reg_wr,
    input  wire logic               reg_rd,
    input  wire logic [15:0]        reg_addr,
    input  wire ctos_pkg::ctos_word_t reg_wdata,
    output logic                    reg_rvalid,
    output ctos_pkg::ctos_word_t    reg_rdata,
    // Counter pins
    input  wire logic               gate_input,
    input  wire logic               trigger_input,
    output logic                    counter_out
);
    import ctos_pkg::*;

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    logic [`CTOS_CTRL_WIDTH-1:0] counter_control_oneshot;
    logic                        toggle_const;
    logic [`CTOS_IRQ_WIDTH-1:0]  counter_irq_cause;
    ctos_word_t                  counter_readback_value;
    ctos_word_t                  const_a_first;
    ctos_word_t                  const_a_second;
    ctos_word_t                  const_b_first;
    ctos_word_t                  const_b_second;

    ctos_state_t state;
    ctos_word_t  count;
    ctos_word_t  rate_acc;
    logic        pulse_active;
    logic        trig_prev;

    logic        wr_ctrl;
    logic        wr_cmd;
    logic        wr_clear;
    logic        soft_reset;
    logic        sw_trigger;
    logic        rb_load;
    logic        oneshot_mode;
    logic        gate_ok;
    logic        trig_level;
    logic        trigger;
    logic        tick;
    logic        run;
    logic        toggle_out;
    ctos_word_t  rate_hz;
    ctos_word_t  sel_a;
    ctos_word_t  sel_b;

    assign wr_ctrl  = reg_wr && (reg_addr == `CTOS_OFF_CTRL);
    assign wr_cmd   = reg_wr && (reg_addr == `CTOS_OFF_CMD);
    assign wr_clear = reg_wr && (reg_addr == `CTOS_OFF_IRQ_CLEAR);
    assign soft_reset = wr_cmd && reg_wdata[`CTOS_CMD_SOFT_RESET];
    assign sw_trigger = wr_cmd && reg_wdata[`CTOS_CMD_TRIGGER];
    assign rb_load    = wr_cmd && reg_wdata[`CTOS_CMD_RB_LOAD];

    assign oneshot_mode = counter_control_oneshot[`CTOS_MODE_MSB:`CTOS_MODE_LSB]
                          == `CTOS_MODE_ONESHOT;

    // ------------------------------------------------------------
    // Gate and trigger decode
    // ------------------------------------------------------------
    always_comb
    begin
        case (counter_control_oneshot[`CTOS_GATE_MSB:`CTOS_GATE_LSB])
            `CTOS_SEL_ACT_LOW:  gate_ok = !gate_input;
            `CTOS_SEL_ACT_HIGH: gate_ok = gate_input;
            default:            gate_ok = 1'b1;
        endcase
    end

    always_comb
    begin
        case (counter_control_oneshot[`CTOS_TRIG_MSB:`CTOS_TRIG_LSB])
            `CTOS_SEL_ACT_LOW:  trig_level = !trigger_input;
            `CTOS_SEL_ACT_HIGH: trig_level = trigger_input;
            default:            trig_level = 1'b0;
        endcase
    end

    // A held trigger level starts only one pulse: act on its leading edge
    assign trigger = sw_trigger || (trig_level && !trig_prev);

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            trig_prev <= 1'b0;
        else
            trig_prev <= trig_level;
    end

    // ------------------------------------------------------------
    // Clock-enable rate generator
    // ------------------------------------------------------------
    // Rates above the system clock saturate to a tick every cycle.
    always_comb
    begin
        case (counter_control_oneshot[`CTOS_RATE_MSB:`CTOS_RATE_LSB])
            3'h0:    rate_hz = `CTOS_RATE_0_HZ;
            3'h1:    rate_hz = `CTOS_RATE_1_HZ;
            3'h2:    rate_hz = `CTOS_RATE_2_HZ;
            3'h3:    rate_hz = `CTOS_RATE_3_HZ;
            3'h4:    rate_hz = `CTOS_RATE_4_HZ;
            default: rate_hz = 32'h0000_0000;
        endcase
    end

    assign tick = (rate_hz >= `CTOS_CLK_HZ)
                  || (rate_acc + rate_hz >= `CTOS_CLK_HZ);

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || soft_reset)
            rate_acc <= 32'h0000_0000;
        else if (rate_hz >= `CTOS_CLK_HZ)
            rate_acc <= 32'h0000_0000;
        else if (tick)
            rate_acc <= rate_acc + rate_hz - `CTOS_CLK_HZ;
        else
            rate_acc <= rate_acc + rate_hz;
    end

    assign run = tick && gate_ok;

    // ------------------------------------------------------------
    // Constant selection
    // ------------------------------------------------------------
    assign sel_a = toggle_const ? const_a_second : const_a_first;
    assign sel_b = toggle_const ? const_b_second : const_b_first;

    // ------------------------------------------------------------
    // One-shot sequencer
    // ------------------------------------------------------------
    // Triggers outside idle are ignored; the host must wait out B.
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || soft_reset || !oneshot_mode)
        begin
            state        <= CTOS_IDLE;
            count        <= 32'h0000_0000;
            pulse_active <= 1'b0;
        end
        else
        begin
            case (state)
                CTOS_IDLE:
                begin
                    if (trigger)
                    begin
                        count <= sel_a;
                        state <= CTOS_DELAY;
                    end
                end
                CTOS_DELAY:
                begin
                    if (run && count == 32'h0000_0000)
                    begin
                        pulse_active <= 1'b1;
                        count        <= sel_b;
                        state        <= CTOS_ACTIVE;
                    end
                    else if (run)
                        count <= count - 32'h0000_0001;
                end
                CTOS_ACTIVE:
                begin
                    if (run && count == 32'h0000_0000)
                    begin
                        pulse_active <= 1'b0;
                        state        <= CTOS_HOLD;
                    end
                    else if (run)
                        count <= count - 32'h0000_0001;
                end
                CTOS_HOLD:
                    state <= CTOS_IDLE;
                default:
                    state <= CTOS_IDLE;
            endcase
        end
    end

    assign toggle_out = oneshot_mode && run && (count == 32'h0000_0000)
                        && (state == CTOS_DELAY || state == CTOS_ACTIVE);

    // Pin level: pulse_active drives the active level chosen by the polarity
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            counter_out <= 1'b1;
        else
            counter_out <= !(pulse_active
                ^ counter_control_oneshot[`CTOS_POL_BIT]);
    end

    // ------------------------------------------------------------
    // Control and command registers
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            counter_control_oneshot <= `CTOS_CTRL_RESET;
        else if (wr_ctrl)
            counter_control_oneshot <= reg_wdata[`CTOS_CTRL_WIDTH-1:0]
                                       & `CTOS_CTRL_MASK;
    end

    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || soft_reset)
            toggle_const <= 1'b0;
        else if (wr_cmd)
            toggle_const <= reg_wdata[`CTOS_CMD_TOGGLE];
    end

    // ------------------------------------------------------------
    // Constant registers, written as whole words only
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || soft_reset)
        begin
            const_a_first  <= 32'h0000_0000;
            const_a_second <= 32'h0000_0000;
            const_b_first  <= 32'h0000_0000;
            const_b_second <= 32'h0000_0000;
        end
        else if (reg_wr)
        begin
            if (reg_addr == `CTOS_OFF_CONST_A1)
                const_a_first <= reg_wdata;
            if (reg_addr == `CTOS_OFF_CONST_A2)
                const_a_second <= reg_wdata;
            if (reg_addr == `CTOS_OFF_CONST_B1)
                const_b_first <= reg_wdata;
            if (reg_addr == `CTOS_OFF_CONST_B2)
                const_b_second <= reg_wdata;
        end
    end

    // ------------------------------------------------------------
    // Read-back register
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            counter_readback_value <= 32'h0000_0000;
        else if (rb_load)
            counter_readback_value <= count;
    end

    // ------------------------------------------------------------
    // Interrupt cause: set beats a same-cycle clear
    // ------------------------------------------------------------
    // Bits 0,1,2,4,5 belong to modes this block does not implement.
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            counter_irq_cause <= '0;
        else
        begin
            if (wr_clear)
                counter_irq_cause <= counter_irq_cause
                    & ~reg_wdata[`CTOS_IRQ_WIDTH-1:0];
            if (toggle_out)
                counter_irq_cause[`CTOS_IRQ_TRANSITION] <= 1'b1;
            counter_irq_cause[0] <= 1'b0;
            counter_irq_cause[1] <= 1'b0;
            counter_irq_cause[2] <= 1'b0;
            counter_irq_cause[4] <= 1'b0;
            counter_irq_cause[5] <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // Read port: answer one cycle after the strobe
    // ------------------------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
        begin
            reg_rvalid <= 1'b0;
            reg_rdata  <= 32'h0000_0000;
        end
        else
        begin
            reg_rvalid <= reg_rd;
            if (!reg_rd)
                reg_rdata <= 32'h0000_0000;
            else
            begin
                case (reg_addr)
                    `CTOS_OFF_CTRL:
                        reg_rdata <= {16'h0000, counter_control_oneshot};
                    `CTOS_OFF_CMD:
                        reg_rdata <= {31'h0000_0000, toggle_const};
                    `CTOS_OFF_IRQ_CAUSE:
                        reg_rdata <= {26'h000_0000, counter_irq_cause};
                    `CTOS_OFF_READBACK:
                        reg_rdata <= counter_readback_value;
                    `CTOS_OFF_CONST_A1: reg_rdata <= const_a_first;
                    `CTOS_OFF_CONST_A2: reg_rdata <= const_a_second;
                    `CTOS_OFF_CONST_B1: reg_rdata <= const_b_first;
                    `CTOS_OFF_CONST_B2: reg_rdata <= const_b_second;
                    default:            reg_rdata <= 32'h0000_0000;
                endcase
            end
        end
    end

endmodule

/* File: src/ctos_pkg.sv */
package ctos_pkg;

    typedef enum logic [3:0]
    {
        CTOS_IDLE   = 4'b0001,
        CTOS_DELAY  = 4'b0010,
        CTOS_ACTIVE = 4'b0100,
        CTOS_HOLD   = 4'b1000
    } ctos_state_t;

    typedef logic [31:0] ctos_word_t;

endpackage

/* File: tb/ctos_host_model.sv */
`timescale 1ns/10ps
module ctos_host_model
(
    // Clock
    input  wire logic                 ref_clk,
    // Register access
    output logic                      reg_wr,
    output logic                      reg_rd,
    output logic [15:0]               reg_addr,
    output ctos_pkg::ctos_word_t      reg_wdata,
    input  wire logic                 reg_rvalid,
    input  wire ctos_pkg::ctos_word_t reg_rdata
);
    import ctos_pkg::*;
    initial
    begin
        reg_wr    = 1'b0;
        reg_rd    = 1'b0;
        reg_addr  = 16'h0000;
        reg_wdata = 32'h0;
    end
    // Whole words only; released lines show the inverse, not stale data
    task automatic wr(input logic [15:0] a, input ctos_word_t v);
        @(posedge ref_clk);
        #1;
        reg_addr  = a;
        reg_wdata = v;
        reg_wr    = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_wr    = 1'b0;
        reg_addr  = ~a;
        reg_wdata = ~v;
    endtask
    task automatic rd(input logic [15:0] a, output ctos_word_t v);
        @(posedge ref_clk);
        #1;
        reg_addr = a;
        reg_rd   = 1'b1;
        @(posedge ref_clk);
        #1;
        reg_rd   = 1'b0;
        reg_addr = ~a;
        v        = (reg_rvalid === 1'b1) ? reg_rdata : 'x;
    endtask
endmodule

/* File: tb/ctos_oneshot_regs_monitor.sv */
`timescale 1ns/10ps
`include "ctos_defs.svh"
module ctos_oneshot_regs_monitor
(
    // Clock and reset
    input wire logic                 ref_clk,
    input wire logic                 reset_n,
    // Register access
    input wire logic                 reg_wr,
    input wire logic                 reg_rd,
    input wire logic [15:0]          reg_addr,
    input wire ctos_pkg::ctos_word_t reg_wdata,
    input wire logic                 reg_rvalid,
    input wire ctos_pkg::ctos_word_t reg_rdata,
    // Counter pins
    input wire logic                 gate_input,
    input wire logic                 trigger_input,
    input wire logic                 counter_out
);
    import ctos_pkg::*;
    logic [15:0] ctrl_q;
    ctos_word_t  a1_q;
    logic [2:0]  gate_cnt;
    logic        blocked;
    default clocking cb @(posedge ref_clk);
    endclocking
    default disable iff (!reset_n);
    // --------------------------------------------
    // Shadows of what software wrote
    // --------------------------------------------
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            ctrl_q <= 16'h0000;
        else if (reg_wr && reg_addr == `CTOS_OFF_CTRL)
            ctrl_q <= reg_wdata[15:0] & `CTOS_CTRL_MASK;
    end
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n)
            a1_q <= 32'h0;
        else if (reg_wr && reg_addr == `CTOS_OFF_CONST_A1)
            a1_q <= reg_wdata;
        else if (reg_wr && reg_addr == `CTOS_OFF_CMD && reg_wdata[3])
            a1_q <= 32'h0;
    end
    assign blocked = (ctrl_q[5:4] == 2'h1) ? gate_input :
                     (ctrl_q[5:4] == 2'h2) ? !gate_input : 1'b0;
    // Gate is sampled, so only a settled block is judged
    always_ff @(posedge ref_clk)
    begin
        if (!reset_n || !blocked || reg_wr)
            gate_cnt <= 3'h0;
        else if (gate_cnt != 3'h7)
            gate_cnt <= gate_cnt + 3'h1;
    end
    // --------------------------------------------
    // Properties
    // --------------------------------------------
    property p_read_answer;
        reg_rd |=> reg_rvalid;
    endproperty
    a_read_answer: assert property (p_read_answer)
        else $error("read got no answer");
    property p_one_answer;
        !reg_rd |=> !reg_rvalid;
    endproperty
    a_one_answer: assert property (p_one_answer)
        else $error("answer without read");
    property p_quiet_data;
        !reg_rvalid |-> reg_rdata == 32'h0;
    endproperty
    a_quiet_data: assert property (p_quiet_data)
        else $error("read data not zero when idle");
    property p_ctrl_read;
        reg_rd && reg_addr == `CTOS_OFF_CTRL
            |=> reg_rdata == {16'h0000, ctrl_q};
    endproperty
    a_ctrl_read: assert property (p_ctrl_read)
        else $error("control read back wrong");
    property p_irq_read;
        reg_rd && reg_addr == `CTOS_OFF_IRQ_CAUSE
            |=> (reg_rdata & 32'hfffffff7) == 32'h0;
    endproperty
    a_irq_read: assert property (p_irq_read)
        else $error("unexpected cause bit set");
    property p_a1_read;
        reg_rd && reg_addr == `CTOS_OFF_CONST_A1 |=> reg_rdata == a1_q;
    endproperty
    a_a1_read: assert property (p_a1_read)
        else $error("constant A1 read back wrong");
    property p_idle_level;
        ctrl_q[2:0] != `CTOS_MODE_ONESHOT && $stable(ctrl_q)
            && ctrl_q == $past(ctrl_q, 2)
            |-> counter_out == !ctrl_q[3];
    endproperty
    a_idle_level: assert property (p_idle_level)
        else $error("output not at inactive level");
    property p_gate_hold;
        gate_cnt >= 3'h3 |-> $stable(counter_out);
    endproperty
    a_gate_hold: assert property (p_gate_hold)
        else $error("output moved while gated off");
endmodule
bind ctos_oneshot_regs ctos_oneshot_regs_monitor mon_u
(
    .ref_clk(ref_clk), .reset_n(reset_n), .reg_wr(reg_wr),
    .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
    .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
    .gate_input(gate_input), .trigger_input(trigger_input),
    .counter_out(counter_out)
);

/* File: tb/ctos_oneshot_regs_tb.sv */
`timescale 1ns/10ps
module ctos_oneshot_regs_tb;
    import ctos_pkg::*;
    logic        ref_clk       = 1'b0;
    logic        reset_n       = 1'b0;
    logic        gate_input    = 1'b0;
    logic        trigger_input = 1'b0;
    logic        reg_wr;
    logic        reg_rd;
    logic        reg_rvalid;
    logic        counter_out;
    logic [15:0] reg_addr;
    ctos_word_t  reg_wdata;
    ctos_word_t  reg_rdata;
    int          error_cnt     = 0;
    int          comparisons   = 0;
    int          d;
    int          w;
    int          lo [5]        = '{50, 24, 11, 10, 10};
    int          hi [5]        = '{53, 27, 14, 10, 10};
    logic [15:0] offs [9]      = '{16'h7070, 16'h7078, 16'h7074,
        16'h707c, 16'h7080, 16'h7084, 16'h7088, 16'h708c, 16'h7000};
    always #50 ref_clk = ~ref_clk;
    ctos_oneshot_regs dut_u
    (
        .ref_clk(ref_clk), .reset_n(reset_n), .reg_wr(reg_wr),
        .reg_rd(reg_rd), .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata),
        .gate_input(gate_input), .trigger_input(trigger_input),
        .counter_out(counter_out)
    );
    ctos_host_model host_u
    (
        .ref_clk(ref_clk), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata),
        .reg_rvalid(reg_rvalid), .reg_rdata(reg_rdata)
    );
    // --------------------------------------------
    // Helpers
    // --------------------------------------------
    task automatic check(input string nm, input ctos_word_t seen,
                         input ctos_word_t exp);
        comparisons++;
        if (seen !== exp)
        begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic rdchk(input string nm, input logic [15:0] a,
                         input ctos_word_t exp);
        ctos_word_t v;
        host_u.rd(a, v);
        check(nm, v, exp);
    endtask
    task automatic pulse(input logic act);
        d = 0;
        w = 0;
        while (counter_out !== act && d < 200)
        begin
            @(posedge ref_clk);
            #1;
            d++;
        end
        // Next trigger only once the B countdown has run out
        while (counter_out === act && w < 200)
        begin
            @(posedge ref_clk);
            #1;
            w++;
        end
    endtask
    task automatic shot(input ctos_word_t cmd, input logic act);
        host_u.wr(16'h7074, cmd);
        pulse(act);
    endtask
    task automatic report_and_stop;
        $display("comparisons %0d mismatches %0d", comparisons, error_cnt);
        if (error_cnt == 0 && comparisons > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask
    // Whole run is near 1450 cycles; allow about four times that
    initial
    begin
        #600000;
        error_cnt++;
        report_and_stop();
    end
    // --------------------------------------------
    // Tests
    // --------------------------------------------
    initial
    begin
        repeat (8) @(posedge ref_clk);
        #1;
        reset_n = 1'b1;
        check("out_idle", {31'h0, counter_out}, 32'h1);
        foreach (offs[i]) rdchk("reset_val", offs[i], 32'h0);
        host_u.wr(16'h7070, 32'h0000ffff);
        rdchk("ctrl_mask", 16'h7070, 32'h00001f3f);
        $display("test reset done");
        host_u.wr(16'h7080, 32'h2);
        host_u.wr(16'h7084, 32'h5);
        host_u.wr(16'h7088, 32'h1);
        host_u.wr(16'h708c, 32'h3);
        host_u.wr(16'h7070, 32'h100f);
        shot(32'h2, 1'b1);
        check("delay_a1", d, 4);
        check("width_b1", w, 2);
        rdchk("irq_set", 16'h7078, 32'h8);
        host_u.wr(16'h7078, 32'h0);
        rdchk("irq_ro", 16'h7078, 32'h8);
        host_u.wr(16'h7060, 32'h8);
        rdchk("irq_clr", 16'h7078, 32'h0);
        host_u.wr(16'h7074, 32'h1);
        rdchk("toggle", 16'h7074, 32'h1);
        shot(32'h3, 1'b1);
        check("delay_a2", d, 7);
        check("width_b2", w, 4);
        $display("test oneshot done");
        host_u.wr(16'h7074, 32'h8);
        foreach (offs[i])
            rdchk("soft_rst", offs[i], (i == 0) ? 32'h100f :
                  (i == 1) ? 32'h8 : 32'h0);
        $display("test soft reset done");
        host_u.wr(16'h7080, 32'h0);
        host_u.wr(16'h7088, 32'h9);
        for (int r = 0; r < 5; r++)
        begin
            host_u.wr(16'h7070, 32'h000f | (ctos_word_t'(r) << 10));
            shot(32'h2, 1'b1);
            check("rate_width", w >= lo[r] && w <= hi[r], 32'h1);
        end
        host_u.wr(16'h7080, 32'h12345678);
        host_u.wr(16'h7070, 32'h140f);
        shot(32'h2, 1'b1);
        check("no_tick", d, 200);
        host_u.wr(16'h7074, 32'h4);
        rdchk("readback", 16'h707c, 32'h12345678);
        host_u.wr(16'h707c, 32'h0);
        rdchk("rb_ro", 16'h707c, 32'h12345678);
        host_u.wr(16'h7070, 32'h0);
        $display("test rate done");
        host_u.wr(16'h7080, 32'h2);
        host_u.wr(16'h7088, 32'h1);
        for (int g = 0; g < 4; g++)
        begin
            gate_input = (g == 1);
            host_u.wr(16'h7070, 32'h100f | (ctos_word_t'(g) << 4));
            host_u.wr(16'h7060, 32'h8);
            shot(32'h2, 1'b1);
            repeat (20) @(posedge ref_clk);
            #1;
            rdchk("gate_irq", 16'h7078,
                  (g == 0 || g == 3) ? 32'h8 : 32'h0);
            if (g == 1 || g == 2)
            begin
                gate_input = !gate_input;
                pulse(1'b1);
                check("gate_width", w, 2);
            end
        end
        $display("test gate done");
        for (int t = 0; t < 4; t++)
        begin
            trigger_input = (t == 1);
            host_u.wr(16'h7070, 32'h1007 | (ctos_word_t'(t) << 8));
            // Let the new code and polarity settle before the edge
            @(posedge ref_clk);
            #1;
            trigger_input = !trigger_input;
            pulse(1'b0);
            check("trig_width", w, (t == 1 || t == 2) ? 2 : 0);
        end
        $display("test trigger done");
        report_and_stop();
    end
endmodule
